// *** hdl/oc_resp_regs.sv ***
/*
 * Overcurrent fault response and warning limit registers of two channels,
 * status flags, alert and per-channel restart sequencing.
 * Assumes commands arrive already decoded from the bus as one-cycle
 * requests, and that the fault threshold, current readings and fault
 * comparators come from outside, synchronous to clk.
 */
// Summary of operation
// - Overcurrent fault sets byte, word and current status bits and raises alert.
// - Response register action applies to overcurrent and output undervoltage faults.
// - Delay field bits 2:0 read as 7, writes ignored.
// - Bits 7:6 read zero, writes ignored.
// - Page 0 selects channel 1, page 1 channel 2, page 11 writes both.
// - Slave channel 2 uses channel 1 values; channel 1 always writable.
// - Write to slave channel 2 is NACKed, invalid command flagged, alert raised.
// - Retry 000 latches output off until faults are cleared.
// - Retry 111 repeats wait then soft start until off or shut down.
// - Retry other than 000 or 111 rejected with cml, ivd and alert.
// - Power-up loads response 00111111; stored user values may replace it.
// - Current above warning sets warn, other, fault-or-warn bits and alert.
// - Warning written above fault threshold flags cml, ivd and alert.
// - Warning word has fixed exponent 11111 and writable 11-bit mantissa.
// - Warning mantissa defaults to 54, valid from 4 to 98.
// - Power-up warning word is 1111 1000 0011 0110, 27 A.
// - Fault threshold mantissa defaults 60, valid 6 to 100, checked against.
`timescale 1ns/1ps
`include "oc_resp_params.svh"

module oc_resp_regs
  import oc_resp_pkg::*;
#(
  parameter int SS_UNIT_CYC = `SS_UNIT_CYC
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire cmd_req_t            cmd,
  output      cmd_rsp_t            rsp,
  input  wire logic                ch2_slave,
  input  wire logic                nvm_load,
  input  wire logic [7:0]          nvm_resp,
  input  wire logic [15:0]         nvm_warn,
  input  wire logic [1:0][10:0]    fault_mant,
  input  wire logic                meas_update,
  input  wire logic [1:0][10:0]    iout_mant,
  input  wire logic [1:0]          oc_fault_in,
  input  wire logic [1:0]          uv_fault_in,
  input  wire logic [1:0]          ch_on,
  input  wire logic [1:0]          other_shutdown,
  input  wire logic                clear_faults,
  output      logic [1:0]          out_en,
  output      chan_status_t [1:0]  chan_status,
  output      comm_status_t        comm_status,
  output      logic                alert_line
);

  // ***************************************************************
  // Register file and command port
  // ***************************************************************
  logic [2:0]   retry_r [2];
  logic [2:0]   retry_nxt [2];
  logic [10:0]  warn_r [2];
  logic [10:0]  warn_nxt [2];
  logic [2:0]   retry_eff [2];
  logic [10:0]  warn_eff [2];
  cmd_rsp_t     rsp_r;
  cmd_rsp_t     rsp_nxt;
  comm_status_t comm_set;
  logic         hit_resp;
  logic         hit_warn;
  logic         page_ok;

  // Slave channel 2 follows channel 1; its own copy is kept but unused
  assign retry_eff[0] = retry_r[0];
  assign warn_eff[0]  = warn_r[0];
  assign retry_eff[1] = ch2_slave ? retry_r[0] : retry_r[1];
  assign warn_eff[1]  = ch2_slave ? warn_r[0] : warn_r[1];

  assign hit_resp = cmd.code == `CMD_OC_RESP;
  assign hit_warn = cmd.code == `CMD_OC_WARN;
  assign page_ok  = cmd.page != 2'h2;

  always_comb
  begin
    logic       sel0;
    logic       sel1;
    logic       rd_ch;
    logic [2:0] wr_retry;
    logic [10:0] wr_mant;
    logic       mant_bad;
    sel0      = 1'b0;
    sel1      = 1'b0;
    rd_ch     = 1'b0;
    wr_retry  = cmd.wdata[`RESP_RETRY_HI:`RESP_RETRY_LO];
    wr_mant   = cmd.wdata[`WARN_MANT_HI:0];
    mant_bad  = 1'b0;
    retry_nxt = retry_r;
    warn_nxt  = warn_r;
    rsp_nxt   = '0;
    comm_set  = '0;
    if (nvm_load)
    begin
      // Stored user values replace the power-up defaults
      retry_nxt[0] = nvm_resp[`RESP_RETRY_HI:`RESP_RETRY_LO];
      retry_nxt[1] = nvm_resp[`RESP_RETRY_HI:`RESP_RETRY_LO];
      warn_nxt[0]  = nvm_warn[`WARN_MANT_HI:0];
      warn_nxt[1]  = nvm_warn[`WARN_MANT_HI:0];
    end
    else if (cmd.valid)
    begin
      if (!(hit_resp || hit_warn) || !page_ok)
      begin
        rsp_nxt.nack                   = 1'b1;
        comm_set.invalid_command_fault = 1'b1;
      end
      else if (cmd.write && cmd.page == `PAGE_CH2 && ch2_slave)
      begin
        rsp_nxt.nack                   = 1'b1;
        comm_set.invalid_command_fault = 1'b1;
      end
      else if (cmd.write)
      begin
        rsp_nxt.ack = 1'b1;
        sel0 = cmd.page == `PAGE_CH1 || cmd.page == `PAGE_BOTH;
        sel1 = (cmd.page == `PAGE_CH2 || cmd.page == `PAGE_BOTH) && !ch2_slave;
        if (hit_resp)
        begin
          // Only the retry field is stored; fixed fields are rebuilt on read
          if (wr_retry != `RETRY_NONE && wr_retry != `RETRY_FOREVER)
          begin
            comm_set.byte_cml = 1'b1;
            comm_set.cml_ivd  = 1'b1;
          end
          else
          begin
            if (sel0)
              retry_nxt[0] = wr_retry;
            if (sel1)
              retry_nxt[1] = wr_retry;
          end
        end
        else
        begin
          mant_bad = $signed(wr_mant) < $signed(`WARN_MANT_MIN) ||
                     $signed(wr_mant) > $signed(`WARN_MANT_MAX);
          if (sel0 && $signed(wr_mant) > $signed(fault_mant[0]))
            mant_bad = 1'b1;
          if (sel1 && $signed(wr_mant) > $signed(fault_mant[1]))
            mant_bad = 1'b1;
          if (mant_bad)
          begin
            comm_set.byte_cml = 1'b1;
            comm_set.cml_ivd  = 1'b1;
          end
          else
          begin
            // Exponent bits of the write are dropped
            if (sel0)
              warn_nxt[0] = wr_mant;
            if (sel1)
              warn_nxt[1] = wr_mant;
          end
        end
      end
      else
      begin
        rsp_nxt.ack = 1'b1;
        rd_ch = cmd.page == `PAGE_CH2;
        if (hit_resp)
          rsp_nxt.rdata = {8'h00, `RESP_RSVD_VAL, retry_eff[rd_ch], `RESP_DELAY_VAL};
        else
          rsp_nxt.rdata = {`WARN_EXP_VAL, warn_eff[rd_ch]};
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      retry_r[0] <= 3'(`RESP_RESET >> `RESP_RETRY_LO);
      retry_r[1] <= 3'(`RESP_RESET >> `RESP_RETRY_LO);
      warn_r[0]  <= 11'(`WARN_RESET);
      warn_r[1]  <= 11'(`WARN_RESET);
      rsp_r      <= '0;
    end
    else
    begin
      retry_r <= retry_nxt;
      warn_r  <= warn_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  assign rsp = rsp_r;

  // ***************************************************************
  // Status flags and alert
  // ***************************************************************
  chan_status_t [1:0] chan_r;
  chan_status_t [1:0] chan_nxt;
  comm_status_t       comm_r;
  comm_status_t       comm_nxt;
  logic               alert_r;
  logic               alert_nxt;
  logic [1:0]         warn_hit;

  always_comb
  begin
    chan_nxt = chan_r;
    for (int i = 0; i < 2; i++)
    begin
      // Set beats a clear arriving in the same cycle
      warn_hit[i] = meas_update && $signed(iout_mant[i]) > $signed(warn_eff[i]);
      if (clear_faults)
        chan_nxt[i] = '0;
      if (oc_fault_in[i])
      begin
        chan_nxt[i].byte_ocf  = 1'b1;
        chan_nxt[i].word_overcurrent_fault_or_warn_bit = 1'b1;
        chan_nxt[i].iout_ocf  = 1'b1;
        chan_nxt[i].iout_ocw  = 1'b1;
      end
      if (warn_hit[i])
      begin
        chan_nxt[i].iout_ocw   = 1'b1;
        chan_nxt[i].byte_other = 1'b1;
        chan_nxt[i].word_overcurrent_fault_or_warn_bit  = 1'b1;
      end
    end
    comm_nxt  = (clear_faults ? '0 : comm_r) | comm_set;
    alert_nxt = |chan_nxt || |comm_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      chan_r  <= '0;
      comm_r  <= '0;
      alert_r <= 1'b0;
    end
    else
    begin
      chan_r  <= chan_nxt;
      comm_r  <= comm_nxt;
      alert_r <= alert_nxt;
    end
  end

  assign chan_status = chan_r;
  assign comm_status = comm_r;
  assign alert_line  = alert_r;

  // ***************************************************************
  // Soft-start time unit divider
  // ***************************************************************
  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic        ss_tick;

  assign ss_tick = div_r == 16'(SS_UNIT_CYC - 1);

  always_comb
  begin
    div_nxt = ss_tick ? 16'h0000 : div_r + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_r <= 16'h0000;
    else
      div_r <= div_nxt;
  end

  // ***************************************************************
  // Per-channel restart sequencing
  // ***************************************************************
  chan_state_t st_r [2];
  chan_state_t st_nxt [2];
  logic [2:0]  cnt_r [2];
  logic [2:0]  cnt_nxt [2];

  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    logic fault;
    // Undervoltage shares the overcurrent response
    assign fault = oc_fault_in[g] || uv_fault_in[g];

    always_comb
    begin
      st_nxt[g]  = st_r[g];
      cnt_nxt[g] = cnt_r[g];
      case (st_r[g])
        ST_OFF:
        begin
          cnt_nxt[g] = 3'h0;
          if (ch_on[g] && !other_shutdown[g])
            st_nxt[g] = ST_SOFT;
        end
        ST_SOFT, ST_RUN:
        begin
          if (fault)
          begin
            cnt_nxt[g] = 3'h0;
            st_nxt[g]  = retry_eff[g] == `RETRY_NONE ? ST_LATCHED : ST_RETRY;
          end
          else if (st_r[g] == ST_SOFT && ss_tick)
          begin
            cnt_nxt[g] = cnt_r[g] + 3'h1;
            if (cnt_r[g] + 3'h1 == `SOFT_START_UNITS)
              st_nxt[g] = ST_RUN;
          end
        end
        ST_RETRY:
        begin
          // Hiccup wait of the fixed delay field before a new soft start
          if (ss_tick)
          begin
            cnt_nxt[g] = cnt_r[g] + 3'h1;
            if (cnt_r[g] == `RETRY_DELAY_UNITS - 3'h1)
            begin
              cnt_nxt[g] = 3'h0;
              st_nxt[g]  = ST_SOFT;
            end
          end
        end
        ST_LATCHED:
        begin
          if (clear_faults)
            st_nxt[g] = ST_OFF;
        end
        default:
          st_nxt[g] = ST_OFF;
      endcase
      // Commanded off or other shutdown ends any retry loop
      if (st_r[g] != ST_LATCHED && (!ch_on[g] || other_shutdown[g]))
        st_nxt[g] = ST_OFF;
    end

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        st_r[g]  <= ST_OFF;
        cnt_r[g] <= 3'h0;
      end
      else
      begin
        st_r[g]  <= st_nxt[g];
        cnt_r[g] <= cnt_nxt[g];
      end
    end

    assign out_en[g] = st_r[g] == ST_SOFT || st_r[g] == ST_RUN;
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  logic rd_resp_req;
  logic bad_retry_wr;
  logic slave_wr;

  assign rd_resp_req  = cmd.valid && !cmd.write && hit_resp && page_ok && !nvm_load;
  assign bad_retry_wr = cmd.valid && cmd.write && hit_resp && page_ok && !nvm_load &&
                        !(cmd.page == `PAGE_CH2 && ch2_slave) &&
                        wr_retry_bad(cmd.wdata[`RESP_RETRY_HI:`RESP_RETRY_LO]);
  assign slave_wr     = cmd.valid && cmd.write && cmd.page == `PAGE_CH2 && ch2_slave &&
                        (hit_resp || hit_warn) && !nvm_load;

  function automatic logic wr_retry_bad(input logic [2:0] v);
    wr_retry_bad = v != `RETRY_NONE && v != `RETRY_FOREVER;
  endfunction : wr_retry_bad

  AST_OCF_STATUS: assert property (@(posedge clk) disable iff (rst)
    oc_fault_in[0] |=> chan_status[0].byte_ocf && chan_status[0].word_overcurrent_fault_or_warn_bit &&
                       chan_status[0].iout_ocf && alert_line)
    else $error("overcurrent fault did not set status and alert");
  AST_UV_LATCH: assert property (@(posedge clk) disable iff (rst)
    (st_r[1] == ST_SOFT || st_r[1] == ST_RUN) && uv_fault_in[1] && ch_on[1] &&
    !other_shutdown[1] && retry_eff[1] == `RETRY_NONE |=> st_r[1] == ST_LATCHED && !out_en[1])
    else $error("undervoltage fault did not follow the response");
  AST_RESP_FIXED: assert property (@(posedge clk) disable iff (rst)
    rd_resp_req |=> rsp.ack && rsp.rdata[2:0] == `RESP_DELAY_VAL)
    else $error("delay field not read back as ones");
  AST_RESP_RSVD: assert property (@(posedge clk) disable iff (rst)
    rd_resp_req |=> rsp.rdata[15:6] == 10'h000)
    else $error("reserved response bits not zero");
  AST_SLAVE_NACK: assert property (@(posedge clk) disable iff (rst)
    slave_wr |=> rsp.nack && !rsp.ack && comm_status.invalid_command_fault && alert_line)
    else $error("write to slave channel not refused");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
    st_r[1] == ST_LATCHED && !clear_faults |=> st_r[1] == ST_LATCHED)
    else $error("latched channel left without a clear");
  AST_RETRY_LOOP: assert property (@(posedge clk) disable iff (rst)
    (st_r[0] == ST_SOFT || st_r[0] == ST_RUN) && oc_fault_in[0] && ch_on[0] &&
    !other_shutdown[0] && retry_eff[0] == `RETRY_FOREVER |=> st_r[0] == ST_RETRY && !out_en[0])
    else $error("unlimited retry did not enter the wait");
  AST_BAD_RETRY: assert property (@(posedge clk) disable iff (rst)
    bad_retry_wr |=> comm_status.byte_cml && comm_status.cml_ivd && alert_line &&
                     retry_r[0] == $past(retry_r[0]))
    else $error("illegal retry value accepted");
  AST_WARN_SET: assert property (@(posedge clk) disable iff (rst)
    warn_hit[0] |=> chan_status[0].iout_ocw && chan_status[0].byte_other &&
                    chan_status[0].word_overcurrent_fault_or_warn_bit && alert_line)
    else $error("current above warning not flagged");
  AST_BOTH_PAGES: assert property (@(posedge clk) disable iff (rst)
    cmd.valid && cmd.write && hit_warn && cmd.page == `PAGE_BOTH && !ch2_slave &&
    !nvm_load && !comm_set.cml_ivd |=> warn_r[0] == warn_r[1])
    else $error("page both did not reach both channels");

  COV_RETRY: cover property (@(posedge clk) disable iff (rst)
    st_r[0] == ST_RETRY ##1 st_r[0] == ST_SOFT);
  COV_LATCH: cover property (@(posedge clk) disable iff (rst)
    st_r[1] == ST_LATCHED ##1 st_r[1] == ST_OFF);
  COV_SLAVE: cover property (@(posedge clk) disable iff (rst) slave_wr);
  COV_WARN: cover property (@(posedge clk) disable iff (rst) warn_hit[0]);

endmodule : oc_resp_regs

// *** include/oc_resp_params.svh ***
/*
 * Holds command codes, field positions, power-up values, limits and timing
 * counts for the overcurrent response and warning registers.
 * Assumes a 100 MHz core clock and inclusion by bare name.
 */
`ifndef OC_RESP_PARAMS_SVH
`define OC_RESP_PARAMS_SVH

// ***************************************************************
// Command codes and pages
// ***************************************************************
`define CMD_OC_RESP       8'h47
`define CMD_OC_WARN       8'h4a
`define PAGE_CH1          2'h0
`define PAGE_CH2          2'h1
`define PAGE_BOTH         2'h3

// ***************************************************************
// Response register layout and power-up value
// ***************************************************************
`define RESP_RETRY_HI     5
`define RESP_RETRY_LO     3
`define RESP_RSVD_VAL     2'h0
`define RESP_DELAY_VAL    3'h7
`define RESP_RESET        8'h3f
`define RETRY_NONE        3'h0
`define RETRY_FOREVER     3'h7

// ***************************************************************
// Warning limit layout, power-up value and range
// ***************************************************************
`define WARN_MANT_HI      10
`define WARN_EXP_VAL      5'h1f
`define WARN_RESET        16'hf836
`define WARN_MANT_RESET   11'h036
`define WARN_MANT_MIN     11'h004
`define WARN_MANT_MAX     11'h062
`define FAULT_MANT_RESET  11'h03c
`define FAULT_MANT_MIN    11'h006
`define FAULT_MANT_MAX    11'h064

// ***************************************************************
// Timing
// ***************************************************************
`define CLK_PERIOD_NS     10
`define SS_UNIT_NS        10000
`define SS_UNIT_CYC       (`SS_UNIT_NS / `CLK_PERIOD_NS)
`define RETRY_DELAY_UNITS 3'h7
`define SOFT_START_UNITS  3'h1

`endif

// *** include/oc_resp_pkg.sv ***
/*
 * Types shared by the overcurrent response block: channel states and the
 * packed carriers of the command port and the status outputs.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package oc_resp_pkg;

  typedef enum logic [2:0]
  {
    ST_OFF     = 3'b000,
    ST_SOFT    = 3'b001,
    ST_RUN     = 3'b010,
    ST_RETRY   = 3'b011,
    ST_LATCHED = 3'b100
  } chan_state_t;

  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [1:0]  page;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed
  {
    logic        ack;
    logic        nack;
    logic [15:0] rdata;
  } cmd_rsp_t;

  typedef struct packed
  {
    logic byte_ocf;
    logic byte_other;
    logic word_overcurrent_fault_or_warn_bit;
    logic iout_ocf;
    logic iout_ocw;
  } chan_status_t;

  typedef struct packed
  {
    logic byte_cml;
    logic cml_ivd;
    logic invalid_command_fault;
  } comm_status_t;

endpackage : oc_resp_pkg

// *** tb/oc_host_model.sv ***
/*
 * Host side of the paged command port: issues one command, waits for
 * the answer. Assumes rsp is registered and answers one cycle later.
 */
`timescale 1ns/1ps

module oc_host_model
  import oc_resp_pkg::*;
(
  input  wire logic     clk,
  output      cmd_req_t cmd,
  input  wire cmd_rsp_t rsp
);
  // ********
  // Command issue
  // ********
  initial cmd = '0;

  // Limits and pages pass unchecked; callers also send out-of-range values and page both
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [1:0] page,
                      input logic [15:0] wd, output cmd_rsp_t r, output logic ok);
    int i;
    ok = 1'b0;
    r  = '0;
    @(posedge clk);
    cmd <= '{valid: 1'b1, write: wr, code: code, page: page, wdata: wd};
    @(posedge clk);
    // Released data shows a changed pattern, not the old word
    cmd <= '{valid: 1'b0, write: ~wr, code: ~code, page: ~page, wdata: ~wd};
    for (i = 0; i < 4 && !ok; i++)
    begin
      #1;
      if (rsp.ack === 1'b1 || rsp.nack === 1'b1)
      begin
        ok = 1'b1;
        r  = rsp;
      end
      else
        @(posedge clk);
    end
  endtask : xfer
endmodule : oc_host_model

// *** tb/oc_resp_regs_tb.sv ***
/*
 * Self-checking bench of the overcurrent response registers.
 * Assumes the host model above and a shortened soft-start unit.
 */
`timescale 1ns/1ps
`include "oc_resp_params.svh"

module oc_resp_regs_tb
  import oc_resp_pkg::*;
;
  localparam int SSU = 4;
  logic               clk;
  logic               rst;
  logic               ch2_slave;
  logic               nvm_load;
  logic               meas_update;
  logic               clear_faults;
  cmd_req_t           cmd;
  cmd_rsp_t           rsp;
  logic [7:0]         nvm_resp;
  logic [15:0]        nvm_warn;
  logic [1:0][10:0]   fault_mant;
  logic [1:0][10:0]   iout_mant;
  logic [1:0]         oc_f;
  logic [1:0]         uv_f;
  logic [1:0]         ch_on;
  logic [1:0]         oth;
  logic [1:0]         out_en;
  chan_status_t [1:0] cst;
  comm_status_t       cms;
  logic               alert;
  int                 err_total;
  int                 n_checks;
  int                 n;

  oc_host_model h (.clk(clk), .cmd(cmd), .rsp(rsp));

  oc_resp_regs #(.SS_UNIT_CYC(SSU)) uut (
    .clk(clk), .rst(rst), .cmd(cmd), .rsp(rsp), .ch2_slave(ch2_slave),
    .nvm_load(nvm_load), .nvm_resp(nvm_resp), .nvm_warn(nvm_warn),
    .fault_mant(fault_mant), .meas_update(meas_update), .iout_mant(iout_mant),
    .oc_fault_in(oc_f), .uv_fault_in(uv_f), .ch_on(ch_on), .other_shutdown(oth),
    .clear_faults(clear_faults), .out_en(out_en), .chan_status(cst),
    .comm_status(cms), .alert_line(alert));

  always #5 clk = ~clk;

  // ********
  // Shared tasks
  // ********
  task automatic final_report();
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp_bit(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask : cmp_bit

  task automatic tmo();
    err_total++;
    final_report();
  endtask : tmo

  task automatic wr(input logic [7:0] c, input logic [1:0] p, input logic [15:0] d,
                    input logic nk);
    cmd_rsp_t r;
    logic     ok;
    h.xfer(1'b1, c, p, d, r, ok);
    if (!ok)
      tmo();
    cmp_bit(r.nack, nk);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [1:0] p, input logic [15:0] e);
    cmd_rsp_t r;
    logic     ok;
    h.xfer(1'b0, c, p, 16'h0000, r, ok);
    if (!ok)
      tmo();
    cmp16(r.rdata, e);
  endtask : rd

  task automatic clr();
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    #1;
    cmp16({3'h0, cms, cst}, 16'h0000);
    cmp_bit(alert, 1'b0);
  endtask : clr

  task automatic meas(input logic [10:0] a, input logic [10:0] b);
    @(posedge clk);
    iout_mant   <= {b, a};
    meas_update <= 1'b1;
    @(posedge clk);
    meas_update <= 1'b0;
    #1;
  endtask : meas

  task automatic nvm(input logic [7:0] r, input logic [15:0] w);
    @(posedge clk);
    nvm_resp <= r;
    nvm_warn <= w;
    nvm_load <= 1'b1;
    @(posedge clk);
    nvm_load <= 1'b0;
  endtask : nvm

  task automatic wait_en(input int ch, input logic v, output int cnt);
    cnt = 0;
    while (out_en[ch] !== v)
    begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > 200)
        tmo();
    end
  endtask : wait_en

  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    rd(`CMD_OC_RESP, `PAGE_CH1, 16'h003f);
    rd(`CMD_OC_WARN, `PAGE_CH2, 16'hf836);
    wr(`CMD_OC_RESP, `PAGE_CH1, 16'hffc0, 1'b0);
    rd(`CMD_OC_RESP, `PAGE_CH1, 16'h0007);
    wr(`CMD_OC_RESP, `PAGE_CH1, 16'h0010, 1'b0);
    cmp16({13'h0000, cms}, 16'h0006);
    cmp_bit(alert, 1'b1);
    rd(`CMD_OC_RESP, `PAGE_CH1, 16'h0007);
    wr(`CMD_OC_RESP, `PAGE_CH1, 16'h0038, 1'b0);
    rd(`CMD_OC_RESP, `PAGE_CH1, 16'h003f);
    clr();
  endtask : t_regs

  task automatic t_warn();
    wr(`CMD_OC_WARN, `PAGE_BOTH, 16'hf832, 1'b0);
    rd(`CMD_OC_WARN, `PAGE_CH1, 16'hf832);
    wr(`CMD_OC_WARN, `PAGE_CH2, 16'h0030, 1'b0);
    rd(`CMD_OC_WARN, `PAGE_CH2, 16'hf830);
    rd(`CMD_OC_WARN, `PAGE_CH1, 16'hf832);
    @(posedge clk);
    fault_mant <= {11'h020, 11'h064};
    wr(`CMD_OC_WARN, `PAGE_CH1, 16'hf862, 1'b0);
    wr(`CMD_OC_WARN, `PAGE_CH1, 16'hf863, 1'b0);
    cmp16({13'h0000, cms}, 16'h0006);
    rd(`CMD_OC_WARN, `PAGE_CH1, 16'hf862);
    clr();
    wr(`CMD_OC_WARN, `PAGE_CH1, 16'hf803, 1'b0);
    cmp_bit(cms.cml_ivd, 1'b1);
    clr();
    wr(`CMD_OC_WARN, `PAGE_CH2, 16'hf821, 1'b0);
    cmp16({13'h0000, cms}, 16'h0006);
    cmp_bit(alert, 1'b1);
    rd(`CMD_OC_WARN, `PAGE_CH2, 16'hf830);
    clr();
    wr(`CMD_OC_WARN, `PAGE_CH2, 16'hf820, 1'b0);
    cmp_bit(alert, 1'b0);
    rd(`CMD_OC_WARN, `PAGE_CH2, 16'hf820);
    @(posedge clk);
    fault_mant <= {11'h03c, 11'h03c};
  endtask : t_warn

  task automatic t_nvm();
    nvm(8'h00, 16'h0040);
    rd(`CMD_OC_RESP, `PAGE_CH2, 16'h0007);
    rd(`CMD_OC_WARN, `PAGE_CH1, 16'hf840);
    nvm(8'h3f, 16'hf836);
    rd(`CMD_OC_WARN, `PAGE_CH2, 16'hf836);
  endtask : t_nvm

  task automatic t_slave();
    @(posedge clk);
    ch2_slave <= 1'b1;
    wr(`CMD_OC_WARN, `PAGE_CH2, 16'hf830, 1'b1);
    cmp16({13'h0000, cms}, 16'h0001);
    cmp_bit(alert, 1'b1);
    clr();
    wr(`CMD_OC_WARN, `PAGE_CH1, 16'hf834, 1'b0);
    wr(`CMD_OC_WARN, `PAGE_BOTH, 16'hf834, 1'b0);
    rd(`CMD_OC_WARN, `PAGE_CH2, 16'hf834);
    wr(8'h99, `PAGE_CH1, 16'h0000, 1'b1);
    wr(`CMD_OC_WARN, 2'h2, 16'hf834, 1'b1);
    @(posedge clk);
    ch2_slave <= 1'b0;
    rd(`CMD_OC_WARN, `PAGE_CH2, 16'hf836);
    clr();
  endtask : t_slave

  task automatic t_meas();
    wr(`CMD_OC_WARN, `PAGE_BOTH, 16'hf836, 1'b0);
    meas(11'h036, 11'h036);
    cmp16({6'h00, cst}, 16'h0000);
    meas(11'h037, 11'h036);
    cmp16({6'h00, cst}, 16'h000d);
    cmp_bit(alert, 1'b1);
    clr();
  endtask : t_meas

  task automatic t_retry();
    @(posedge clk);
    ch_on <= 2'b01;
    wait_en(0, 1'b1, n);
    @(posedge clk);
    oc_f <= 2'b01;
    @(posedge clk);
    oc_f <= 2'b00;
    #1;
    cmp16({6'h00, cst}, 16'h0017);
    cmp_bit(alert, 1'b1);
    @(posedge clk);
    #1;
    cmp_bit(out_en[0], 1'b0);
    wait_en(0, 1'b1, n);
    cmp_bit(n >= 6 * SSU - 2 && n <= 7 * SSU + 2, 1'b1);
    @(posedge clk);
    uv_f <= 2'b01;
    @(posedge clk);
    uv_f <= 2'b00;
    wait_en(0, 1'b0, n);
    cmp_bit(n < 3, 1'b1);
    wait_en(0, 1'b1, n);
    cmp_bit(n >= 6 * SSU - 2 && n <= 7 * SSU + 2, 1'b1);
    @(posedge clk);
    oth <= 2'b01;
    wait_en(0, 1'b0, n);
    repeat (40) @(posedge clk);
    #1;
    cmp_bit(out_en[0], 1'b0);
    @(posedge clk);
    oth   <= 2'b00;
    ch_on <= 2'b00;
    clr();
  endtask : t_retry

  task automatic t_latch();
    wr(`CMD_OC_RESP, `PAGE_CH2, 16'h0000, 1'b0);
    @(posedge clk);
    ch_on <= 2'b10;
    wait_en(1, 1'b1, n);
    @(posedge clk);
    uv_f <= 2'b10;
    @(posedge clk);
    uv_f <= 2'b00;
    wait_en(1, 1'b0, n);
    repeat (50) @(posedge clk);
    #1;
    cmp_bit(out_en[1], 1'b0);
    clr();
    wait_en(1, 1'b1, n);
    cmp_bit(out_en[1], 1'b1);
    @(posedge clk);
    ch_on <= 2'b00;
  endtask : t_latch

  // ********
  // Main sequence
  // ********
  initial
  begin
    clk          = 1'b0;
    rst          = 1'b1;
    ch2_slave    = 1'b0;
    nvm_load     = 1'b0;
    meas_update  = 1'b0;
    clear_faults = 1'b0;
    nvm_resp     = 8'h00;
    nvm_warn     = 16'h0000;
    fault_mant   = {11'h03c, 11'h03c};
    iout_mant    = '0;
    oc_f         = 2'b00;
    uv_f         = 2'b00;
    ch_on        = 2'b00;
    oth          = 2'b00;
    err_total    = 0;
    n_checks     = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_warn();
    t_nvm();
    t_slave();
    t_meas();
    t_retry();
    t_latch();
    final_report();
  end
endmodule : oc_resp_regs_tb
